// file: verilog/ics_regs.vh
// Register offsets, mask bits and timing constants for the calibration sequencer
`ifndef ICS_REGS_VH
`define ICS_REGS_VH

// APB byte offsets
`define ICS_CTRL_ADDR      12'h000
`define ICS_MASK_ADDR      12'h004
`define ICS_STATUS_ADDR    12'h008
`define ICS_DONE_ADDR      12'h00C
`define ICS_FAULT_ADDR     12'h010
`define ICS_ADCSEL_ADDR    12'h014

// Control fields
`define ICS_CTRL_START     0
`define ICS_CTRL_RETUNE    1
`define ICS_CTRL_FULL      2

// Status fields
`define ICS_ST_BUSY        0
`define ICS_ST_DONE        1
`define ICS_ST_FAIL        2
`define ICS_ST_PORT_EN     3

// Mask bit positions (transmit, D0..D7)
`define ICS_B_TX_QUAD      5'h00
`define ICS_B_TX_LEAK      5'h01
`define ICS_B_TX_LBDLY     5'h02
`define ICS_B_TX_DUTY      5'h03
`define ICS_B_TX_BBF       5'h04
`define ICS_B_TX_FGD       5'h05
`define ICS_B_TX_ATT       5'h06
`define ICS_B_TX_DAC       5'h07
// Receive bits used by the sequencer
`define ICS_B_RX_RC        5'h09
`define ICS_B_RX_FLASH     5'h0A
`define ICS_B_RX_DAC       5'h0B
`define ICS_B_RX_DUTY      5'h0C
`define ICS_B_RX_LOWPOWER_ADC_CAL     5'h0D
`define ICS_B_RX_CUTOFF    5'h0E
`define ICS_B_RX_GDLY      5'h0F
`define ICS_B_RX_QTONE     5'h10
`define ICS_B_RX_QFLAT     5'h11
`define ICS_B_RX_LODLY     5'h12
`define ICS_B_RX_RFOFS     5'h13
`define ICS_B_RX_GPDLY     5'h14

// Reset values and fixed masks
`define ICS_MASK_RESET     32'hFFFF_FFFF
`define ICS_LO_RETUNE_MASK 32'h000B_902B
`define ICS_OVERRIDE_MASK  32'h000A_0007
`define ICS_FULL_MASK      32'h001F_F7FF
// Bits D3..D7 and the non-overridable receive bits always run
`define ICS_FORCED_MASK    32'h0015_FEF8

// Step length, in ns, and tone count for the tone-swept quadrature step
`define ICS_STEP_NS        1000
`define ICS_CLK_NS         100
`define ICS_TONES          4

`endif

// file: verilog/ics_sequencer.v
// Initial calibration sequencer with APB register access
`timescale 1ns/1ps
`include "ics_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module ics_sequencer #(
   parameter STEP_CYCLES = (`ICS_STEP_NS + `ICS_CLK_NS - 1) / `ICS_CLK_NS,
   parameter TONES       = `ICS_TONES
) (
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Calibration engine result
   input  wire        step_fail,
   // Datapath control
   output reg         data_port_en,
   output reg         tone_inject,
   output reg         loopback_en,
   output reg         tx_siggen_en,
   output reg         rx_cal_active,
   output reg  [4:0]  cur_step,
   output reg         apply_digital,
   output reg         apply_analog,
   output reg         apply_fast_adc,
   output reg         apply_lowpower_adc
);

   // Step order: prerequisites first
   localparam NSTEPS = 20;
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_RUN  = 3'b010;
   localparam [2:0] S_DONE = 3'b100;

   reg  [2:0]  state;
   reg  [31:0] cal_mask;
   reg  [31:0] run_mask;
   reg  [31:0] done_bits;
   reg  [31:0] fail_bits;
   reg         adc_lowpower;
   reg         busy;
   reg         seq_done;
   reg         seq_fail;
   reg  [4:0]  idx;
   reg  [15:0] cnt;
   reg  [7:0]  tone;
   reg  [4:0]  bitpos;
   reg  [4:0]  step_bit;
   reg         start_req;
   reg  [31:0] start_mask;

   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;

   ////////////////////////////////////////////////////////////////////////////
   // Dependency ordered table; index to mask bit
   // D7, D4, D3 transmit bits first; D2, D0, D1, D5, D6 last
   always @* begin
      case (idx)
         5'd0:    step_bit = `ICS_B_TX_DAC;
         5'd1:    step_bit = `ICS_B_TX_BBF;
         5'd2:    step_bit = `ICS_B_TX_DUTY;
         5'd3:    step_bit = `ICS_B_RX_RC;
         5'd4:    step_bit = `ICS_B_RX_FLASH;
         5'd5:    step_bit = `ICS_B_RX_DAC;
         5'd6:    step_bit = `ICS_B_RX_LOWPOWER_ADC_CAL;
         5'd7:    step_bit = `ICS_B_RX_CUTOFF;
         5'd8:    step_bit = `ICS_B_RX_DUTY;
         5'd9:    step_bit = `ICS_B_RX_GDLY;
         5'd10:   step_bit = `ICS_B_RX_RFOFS;
         5'd11:   step_bit = `ICS_B_RX_LODLY;
         5'd12:   step_bit = `ICS_B_RX_GPDLY;
         5'd13:   step_bit = `ICS_B_RX_QTONE;
         5'd14:   step_bit = `ICS_B_RX_QFLAT;
         5'd15:   step_bit = `ICS_B_TX_LBDLY;
         5'd16:   step_bit = `ICS_B_TX_QUAD;
         5'd17:   step_bit = `ICS_B_TX_LEAK;
         5'd18:   step_bit = `ICS_B_TX_FGD;
         default: step_bit = `ICS_B_TX_ATT;
      endcase
   end

   // Step kind decode
   wire is_rx = (step_bit >= 5'd9);
   wire is_adc = (step_bit == `ICS_B_RX_RC) | (step_bit == `ICS_B_RX_FLASH) |
                 (step_bit == `ICS_B_RX_DAC) | (step_bit == `ICS_B_RX_LOWPOWER_ADC_CAL);
   wire is_rx_dig = (step_bit == `ICS_B_RX_QTONE) |
                    (step_bit == `ICS_B_RX_QFLAT) |
                    (step_bit == `ICS_B_RX_GPDLY);
   wire is_rx_ana = is_rx & ~is_adc & ~is_rx_dig;
   wire uses_tone = is_rx & ~is_adc & (step_bit != `ICS_B_RX_RFOFS);
   wire needs_lb  = (step_bit == `ICS_B_TX_LBDLY) |
                    (step_bit == `ICS_B_TX_QUAD) |
                    (step_bit == `ICS_B_TX_LEAK) |
                    (step_bit == `ICS_B_TX_DUTY) |
                    (step_bit == `ICS_B_TX_ATT) |
                    (step_bit == `ICS_B_RX_LODLY);
   wire is_quad_tone = (step_bit == `ICS_B_RX_QTONE);
   wire step_sel = run_mask[step_bit];
   wire last_tone = ~is_quad_tone | (tone == TONES[7:0] - 8'h01);
   wire step_end = (cnt == STEP_CYCLES[15:0] - 16'h0001) & last_tone;
   // Engine answers for the step on cur_step, one cycle behind step_bit;
   // a one-cycle step could therefore never report a fault
   wire fail_now = step_fail & (cur_step == step_bit);

   ////////////////////////////////////////////////////////////////////////////
   // Start request from a control write
   always @* begin
      start_req  = 1'b0;
      start_mask = cal_mask;
      if (wr_en && paddr == `ICS_CTRL_ADDR) begin
         if (pwdata[`ICS_CTRL_FULL]) begin
            start_req  = 1'b1;
            start_mask = `ICS_FULL_MASK;
         end else if (pwdata[`ICS_CTRL_RETUNE]) begin
            start_req  = 1'b1;
            start_mask = `ICS_LO_RETUNE_MASK;
         end else if (pwdata[`ICS_CTRL_START]) begin
            start_req  = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state machine; idle ignores none, busy ignores new starts
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= S_IDLE;
         run_mask  <= 32'h0000_0000;
         done_bits <= 32'h0000_0000;
         fail_bits <= 32'h0000_0000;
         busy      <= 1'b0;
         seq_done  <= 1'b0;
         seq_fail  <= 1'b0;
         idx       <= 5'd0;
         cnt       <= 16'h0000;
         tone      <= 8'h00;
      end else begin
         case (state)
            S_IDLE: begin
               if (start_req) begin
                  // mask selects; forced bits always run
                  run_mask  <= (start_mask & `ICS_OVERRIDE_MASK) |
                               `ICS_FORCED_MASK;
                  done_bits <= 32'h0000_0000;
                  fail_bits <= 32'h0000_0000;
                  busy      <= 1'b1;
                  seq_done  <= 1'b0;
                  seq_fail  <= 1'b0;
                  idx       <= 5'd0;
                  cnt       <= 16'h0000;
                  tone      <= 8'h00;
                  state     <= S_RUN;
               end
            end
            S_RUN: begin
               if (!step_sel || step_end) begin
                  if (step_sel) begin
                     done_bits[step_bit] <= 1'b1;
                     if (fail_now) begin
                        fail_bits[step_bit] <= 1'b1;
                        seq_fail <= 1'b1;
                     end
                  end
                  cnt  <= 16'h0000;
                  tone <= 8'h00;
                  if (idx == NSTEPS[4:0] - 5'd1) begin
                     state <= S_DONE;
                  end else begin
                     idx <= idx + 5'd1;
                  end
               end else if (cnt == STEP_CYCLES[15:0] - 16'h0001) begin
                  cnt  <= 16'h0000;
                  tone <= tone + 8'h01;
               end else begin
                  cnt <= cnt + 16'h0001;
                  if (fail_now) begin
                     seq_fail <= 1'b1;
                     fail_bits[step_bit] <= 1'b1;
                  end
               end
            end
            default: begin
               busy     <= 1'b0;
               seq_done <= 1'b1;
               state    <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Datapath controls, registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_port_en       <= 1'b1;
         tone_inject        <= 1'b0;
         loopback_en        <= 1'b0;
         tx_siggen_en       <= 1'b0;
         rx_cal_active      <= 1'b0;
         cur_step           <= 5'd0;
         apply_digital      <= 1'b0;
         apply_analog       <= 1'b0;
         apply_fast_adc     <= 1'b0;
         apply_lowpower_adc <= 1'b0;
      end else begin
         // port off while calibrating; back on after
         data_port_en  <= ~(state == S_RUN);
         // tells the outside to isolate the receiver input
         rx_cal_active <= (state == S_RUN) & step_sel & is_rx;
         // tones for the tone-using receive steps
         tone_inject   <= (state == S_RUN) & step_sel & uses_tone;
         loopback_en   <= (state == S_RUN) & step_sel & needs_lb;
         tx_siggen_en  <= (state == S_RUN) & step_sel & ~is_rx &
                          (step_bit != `ICS_B_TX_DAC);
         cur_step      <= step_bit;
         apply_digital <= (state == S_RUN) & step_sel & step_end &
                          is_rx_dig;
         apply_analog  <= (state == S_RUN) & step_sel & step_end &
                          is_rx_ana;
         // ADC corrections to the ADC in use
         apply_fast_adc     <= (state == S_RUN) & step_sel & step_end &
                               is_adc & ~adc_lowpower;
         apply_lowpower_adc <= (state == S_RUN) & step_sel & step_end &
                               is_adc & adc_lowpower;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; mask held while a sequence runs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_mask     <= `ICS_MASK_RESET;
         adc_lowpower <= 1'b0;
      end else if (wr_en && !busy) begin
         if (paddr == `ICS_MASK_ADDR) begin
            cal_mask <= pwdata;
         end else if (paddr == `ICS_ADCSEL_ADDR) begin
            adc_lowpower <= pwdata[0];
         end
      end
   end

   // APB read path and zero wait state answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            if (paddr == `ICS_MASK_ADDR) begin
               prdata <= cal_mask;
            end else if (paddr == `ICS_STATUS_ADDR) begin
               prdata <= {28'h000_0000, data_port_en, seq_fail,
                          seq_done, busy};
            end else if (paddr == `ICS_DONE_ADDR) begin
               prdata <= done_bits;
            end else if (paddr == `ICS_FAULT_ADDR) begin
               prdata <= fail_bits;
            end else if (paddr == `ICS_ADCSEL_ADDR) begin
               prdata <= {31'h0000_0000, adc_lowpower};
            end else if (paddr != `ICS_CTRL_ADDR) begin
               pslverr <= 1'b1;
            end
         end
      end
   end

endmodule // ics_sequencer

// file: test/ics_seq_props.sv
// Port-level property checker for the calibration sequencer
`timescale 1ns/1ps
module ics_seq_props #(
   parameter STEP_CYCLES = 10,
   parameter TONES       = 4
) (
   input wire       pclk,
   input wire       presetn,
   input wire       psel,
   input wire       penable,
   input wire       pready,
   input wire       pslverr,
   input wire       data_port_en,
   input wire       tone_inject,
   input wire       rx_cal_active,
   input wire [4:0] cur_step,
   input wire       apply_digital,
   input wire       apply_analog,
   input wire       apply_fast_adc,
   input wire       apply_lowpower_adc
);
   localparam int QLEN = TONES * STEP_CYCLES;
   integer run;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Length of the tone sweep step, counted in cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         run <= 0;
      else if (cur_step == 5'd16)
         run <= run + 1;
      else
         run <= 0;
   end

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      pready && psel && penable;
   endsequence

   ready_once_a: assert property (setup_s |=> answer_s ##1 !pready)
      else $error("pready not one access cycle");
   slverr_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   port_off_a: assert property (rx_cal_active |-> !data_port_en)
      else $error("data port on during receive step");
   rf_notone_a: assert property
      (rx_cal_active && cur_step == 5'd19 |-> !tone_inject)
      else $error("tone during RF offset step");
   tone_quiet_a: assert property (tone_inject |-> !data_port_en)
      else $error("tone while data port on");
   sweep_len_a: assert property
      ($past(cur_step) == 5'd16 && cur_step != 5'd16 |-> run == QLEN)
      else $error("tone sweep length wrong");
   apply_dig_a: assert property
      (apply_digital && $past(cur_step) >= 5'd9
       |-> $past(cur_step) inside {5'd16, 5'd17, 5'd20})
      else $error("digital apply after wrong step");
   apply_ana_a: assert property
      (apply_analog && $past(cur_step) >= 5'd9
       |-> $past(cur_step) inside {5'd12, 5'd14, 5'd15, 5'd18, 5'd19})
      else $error("analog apply after wrong step");
   adc_one_a: assert property
      (apply_fast_adc || apply_lowpower_adc
       |-> $past(cur_step) inside {5'd9, 5'd10, 5'd11, 5'd13}
       && !(apply_fast_adc && apply_lowpower_adc))
      else $error("ADC apply wrong");
endmodule // ics_seq_props

bind ics_sequencer ics_seq_props #(.STEP_CYCLES(STEP_CYCLES), .TONES(TONES))
   u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .data_port_en(data_port_en),
   .tone_inject(tone_inject), .rx_cal_active(rx_cal_active),
   .cur_step(cur_step), .apply_digital(apply_digital),
   .apply_analog(apply_analog), .apply_fast_adc(apply_fast_adc),
   .apply_lowpower_adc(apply_lowpower_adc));

// file: test/ics_cal_engine.sv
// Model of the calibration engine and front end beside the sequencer
`timescale 1ns/1ps
module ics_cal_engine (
   // Commanded fault
   input wire       fail_en,
   input wire [4:0] fail_step,
   // From the sequencer
   input wire [4:0] cur_step,
   input wire       rx_cal_active,
   // Results and front end
   output reg       step_fail,
   output reg       lna_on
);
   // Fails only the step the bench names, so faults stay deliberate
   always @* begin
      step_fail = fail_en && (cur_step == fail_step);
      lna_on = !rx_cal_active;
   end
endmodule // ics_cal_engine

// file: test/ics_sequencer_test.sv
// Self-checking bench for the calibration sequencer
`timescale 1ns/1ps
`include "ics_regs.vh"
module ics_sequencer_test;
   reg         pclk = 0;
   reg         presetn = 0;
   reg         psel = 0;
   reg         penable = 0;
   reg         pwrite = 0;
   reg  [11:0] paddr = 0;
   reg  [31:0] pwdata = 0;
   reg         fail_en = 0;
   reg  [4:0]  fail_step = 0;
   wire [31:0] prdata;
   wire        pready, pslverr, step_fail, data_port_en, tone_inject;
   wire        loopback_en, tx_siggen_en, rx_cal_active, lna_on;
   wire        apply_digital, apply_analog, apply_fast_adc, apply_lp;
   wire [4:0]  cur_step;
   integer     num_errors = 0;
   integer     total_checks = 0;
   integer     n_fast = 0;
   integer     n_low = 0;
   integer     n_dig = 0;
   integer     n_ana = 0;
   integer     n_lb = 0;
   integer     n_sg = 0;
   integer     n_bad = 0;
   integer     n_iso = 0;
   integer     sf;
   reg  [31:0] rd;
   reg         er;
   time        ts [0:31];

   always #50 pclk = ~pclk;

   ics_sequencer #(.STEP_CYCLES(3), .TONES(4)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_fail(step_fail), .data_port_en(data_port_en),
      .tone_inject(tone_inject), .loopback_en(loopback_en),
      .tx_siggen_en(tx_siggen_en), .rx_cal_active(rx_cal_active),
      .cur_step(cur_step), .apply_digital(apply_digital),
      .apply_analog(apply_analog), .apply_fast_adc(apply_fast_adc),
      .apply_lowpower_adc(apply_lp));
   ics_cal_engine eng (.fail_en(fail_en), .fail_step(fail_step),
      .cur_step(cur_step), .rx_cal_active(rx_cal_active),
      .step_fail(step_fail), .lna_on(lna_on));

   // Pulse counts and last cycle of each step while running
   always @(posedge pclk) begin
      if (apply_fast_adc === 1'b1) n_fast <= n_fast + 1;
      if (apply_lp === 1'b1) n_low <= n_low + 1;
      if (apply_digital === 1'b1) n_dig <= n_dig + 1;
      if (apply_analog === 1'b1) n_ana <= n_ana + 1;
      if (lna_on === 1'b0) n_iso <= n_iso + 1;
      if (loopback_en === 1'b1 && cur_step == `ICS_B_TX_LBDLY)
         n_lb <= n_lb + 1;
      if (tx_siggen_en === 1'b1 && cur_step == `ICS_B_TX_BBF)
         n_sg <= n_sg + 1;
      // DAC step needs no generator, filter step no loopback
      if ((tx_siggen_en === 1'b1 && cur_step == `ICS_B_TX_DAC) ||
          (loopback_en === 1'b1 && cur_step == `ICS_B_TX_BBF))
         n_bad <= n_bad + 1;
      if (data_port_en === 1'b0) ts[cur_step] <= $time;
   end

   ////////////////////////////////////////////////////////////////////////
   task test_done;
      begin
         $display("checks %0d errors %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   task chk(input [31:0] g, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask

   // One APB transfer, held until pready is seen at an edge
   task apb(input w, input [11:0] a, input [31:0] d);
      integer k;
      begin
         @(posedge pclk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && k < 20) begin
            k = k + 1;
            @(posedge pclk);
         end
         if (pready !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: no pready", $time);
            test_done;
         end
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // Start a run, see the port drop, poll until idle, read run bits
   task run_seq(input [31:0] ctl, input [31:0] mwr);
      integer k;
      begin
         apb(1'b1, `ICS_CTRL_ADDR, ctl);
         repeat (2) @(posedge pclk);
         #1 chk(data_port_en, 0);
         apb(1'b1, `ICS_MASK_ADDR, mwr);
         k = 0;
         rd = 1;
         while (rd[`ICS_ST_BUSY] !== 1'b0 && k < 300) begin
            apb(1'b0, `ICS_STATUS_ADDR, 0);
            k = k + 1;
         end
         if (rd[`ICS_ST_BUSY] !== 1'b0) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: sequence still busy", $time);
            test_done;
         end
         chk(rd[`ICS_ST_DONE], 1);
         chk(data_port_en, 1);
         apb(1'b0, `ICS_DONE_ADDR, 0);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      apb(1'b0, `ICS_MASK_ADDR, 0);
      chk(rd, `ICS_MASK_RESET);
      apb(1'b0, `ICS_STATUS_ADDR, 0);
      chk(rd, 32'h0000_0008);
      // Unmapped address answers zero with an error
      apb(1'b0, 12'h020, 0);
      chk(rd, 32'h0000_0000);
      chk(er, 1);
      $display("test reset done");
      // Cleared mask: only forced steps; mask write while busy ignored
      apb(1'b1, `ICS_MASK_ADDR, 0);
      run_seq(32'h1, 32'hFFFF_FFFF);
      chk(rd & 32'h000A_00FF, 32'h0000_00F8);
      apb(1'b0, `ICS_MASK_ADDR, 0);
      chk(rd, 0);
      $display("test forced done");
      run_seq(32'h2, 0);
      chk(rd & 32'h000A_00FF, 32'h000A_00FB);
      chk(n_low, 0);
      chk(n_fast > 0, 1);
      chk(n_dig > 0, 1);
      chk(n_ana > 0, 1);
      sf = n_fast;
      $display("test retune done");
      apb(1'b1, `ICS_ADCSEL_ADDR, 1);
      run_seq(32'h4, 0);
      chk(rd & 32'h000A_00FF, 32'h000A_00FF);
      chk(n_fast - sf, 0);
      chk(n_low > 0, 1);
      chk(n_lb > 0 && n_sg > 0 && n_bad == 0, 1);
      chk(n_iso > 0, 1);
      chk(ts[7] < ts[0] && ts[4] < ts[0] && ts[2] < ts[0], 1);
      chk(ts[9] < ts[2] && ts[19] < ts[2] && ts[4] < ts[5], 1);
      chk(ts[0] < ts[5] && ts[7] < ts[6] && ts[13] < ts[6], 1);
      $display("test full done");
      // A failing step must be reported at the end of the run
      fail_en <= 1'b1;
      fail_step <= `ICS_B_TX_DAC;
      run_seq(32'h4, 0);
      chk(rd[`ICS_B_TX_DAC], 1);
      apb(1'b0, `ICS_STATUS_ADDR, 0);
      chk(rd[`ICS_ST_FAIL], 1);
      // Only the failing step is marked, none beside it
      apb(1'b0, `ICS_FAULT_ADDR, 0);
      chk(rd, 32'h0000_0080);
      fail_en <= 1'b0;
      $display("test fail done");
      test_done;
   end
endmodule // ics_sequencer_test
